// File: shared/fcsm_params.svh
// Purpose: Timing counts, bus codes and unlock addresses for the flash
//          command sequencer host.
// Assumes: Core clock period of 4 ns.
// Notes:   Strobe and access times are plain defaults; adjust per board.
`ifndef FCSM_PARAMS_SVH
`define FCSM_PARAMS_SVH

// Widths of the flash bus
`define FCSM_ADDR_W          20
`define FCSM_DATA_W          16

// Clock period and bus timing in ns
`define FCSM_CLK_PERIOD_NS   4
`define FCSM_T_SETUP_NS      20
`define FCSM_T_WE_LOW_NS     50
`define FCSM_T_ACCESS_NS     120
`define FCSM_T_RECOVER_NS    30
`define FCSM_SYNC_STAGES     2

// Cycle counts; least times round up
`define FCSM_CYC(t) (((t) + `FCSM_CLK_PERIOD_NS - 1) / `FCSM_CLK_PERIOD_NS)
`define FCSM_SETUP_CYC   `FCSM_CYC(`FCSM_T_SETUP_NS)
`define FCSM_WE_CYC      `FCSM_CYC(`FCSM_T_WE_LOW_NS)
`define FCSM_ACCESS_CYC  (`FCSM_CYC(`FCSM_T_ACCESS_NS) + `FCSM_SYNC_STAGES)
`define FCSM_RECOVER_CYC `FCSM_CYC(`FCSM_T_RECOVER_NS)

// Unlock addresses, word and byte mode
`define FCSM_UNLOCK1_WORD    20'h00555
`define FCSM_UNLOCK2_WORD    20'h002aa
`define FCSM_UNLOCK1_BYTE    20'h00aaa
`define FCSM_UNLOCK2_BYTE    20'h00555

// Command data codes
`define FCSM_CODE_UNLOCK1    16'h00aa
`define FCSM_CODE_UNLOCK2    16'h0055
`define FCSM_CODE_PROGRAM    16'h00a0
`define FCSM_CODE_ERASE_SET  16'h0080
`define FCSM_CODE_IDENT      16'h0090
`define FCSM_CODE_CHIP       16'h0010
`define FCSM_CODE_SECTOR     16'h0030
`define FCSM_CODE_RESUME     16'h0030
`define FCSM_CODE_SUSPEND    16'h00b0
`define FCSM_CODE_RESET      16'h00f0

// Protect-verify offset inside a sector, and the sector mask
`define FCSM_PROT_OFS_WORD   20'h00002
`define FCSM_PROT_OFS_BYTE   20'h00004
`define FCSM_SECTOR_MASK     20'hfff00

// Status bit positions on polling reads
`define FCSM_TOGGLE_BIT      6
`define FCSM_LIMIT_BIT       5

`endif

// File: shared/fcsm_pkg.sv
// Purpose: Types shared by the flash command sequencer host.
// Assumes: fcsm_params.svh supplies the widths.
// Notes:   Operation codes are internal; they are not flash data codes.
`include "fcsm_params.svh"

package fcsm_pkg;

   // Operations the user side can request
   typedef enum logic [3:0] {
      OP_READ,
      OP_RESET,
      OP_IDENT,
      OP_PROT_VERIFY,
      OP_PROGRAM,
      OP_CHIP_ERASE,
      OP_SECTOR_ERASE,
      OP_SUSPEND,
      OP_RESUME
   } fcsm_op_type;

   // One user request
   typedef struct packed {
      fcsm_op_type                 op;
      logic                        byte_mode;
      logic [`FCSM_ADDR_W-1:0]     addr;
      logic [`FCSM_DATA_W-1:0]     data;
   } fcsm_cmd_type;

   // One answer
   typedef struct packed {
      logic [`FCSM_DATA_W-1:0]     data;
      logic                        fail;
      logic                        suspended;
   } fcsm_rsp_type;

   // One flash bus cycle
   typedef struct packed {
      logic [`FCSM_ADDR_W-1:0]     addr;
      logic [`FCSM_DATA_W-1:0]     data;
      logic                        is_read;
   } fcsm_bus_type;

endpackage : fcsm_pkg

// File: design/fcsm_host.sv
// Purpose: Host-side sequencer driving a parallel NOR flash command port.
// Assumes: Flash data input is asynchronous to core_clk.
// Notes:   One request at a time; completion by toggle-bit polling.
// Functional notes
// [RULE1] Program: two unlocks, code A0, then address and value write.
// [RULE2] Device returns polling and toggle status while programming.
// [RULE3] Erase pre-programs, verifies, then erases; toggle bit shows progress.
// [RULE4] Chip erase uses repeated internally timed 10 ms pulses.
// [RULE5] Sector erase pre-programs selected sectors, erases them together.
// [RULE6] Address latched on later falling strobe, data on first rise.
// [RULE7] Device ignores all command writes while programming.
// [RULE8] During sector erase only suspend is accepted.
// [RULE9] After suspend the device stays in read mode.
// [RULE10] After completion the full command set is accepted again.
// [RULE11] Sector erase: six cycles, last puts 30 at sector address.
// [RULE12] Unlock addresses 555/2AA in word mode, AAA/555 in byte mode.
// [RULE13] Upper address bits are don't-care except program/sector addresses.
// [RULE14] Identifier command 90 then reads return identifier codes.
// [RULE15] Identifier mode read at sector offset 02/04 gives protect state.
// [RULE16] Fourth program cycle carries target address and value.
// [RULE17] Chip erase: unlocks, 80, unlocks, then 10.
// [RULE18] A single F0 write aborts a failed program or erase.
// [RULE19] Suspend B0 and resume 30 act only during sector erase.
// [RULE20] Wrong value or order in a sequence returns device to read.
// [RULE21] Device pulse widths and attempt limits are model parameters.
`include "fcsm_params.svh"
`timescale 1ns/1ps
`default_nettype none

module fcsm_host
   import fcsm_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   input  wire logic                     clk_en,
   input  wire logic                     cmd_valid,
   input  wire fcsm_cmd_type             cmd,
   output logic                          cmd_ready,
   output logic                          rsp_valid,
   output fcsm_rsp_type                  rsp,
   output logic [`FCSM_ADDR_W-1:0]       flash_addr,
   output logic [`FCSM_DATA_W-1:0]       flash_dq_out,
   output logic                          flash_dq_oe_n,
   input  wire logic [`FCSM_DATA_W-1:0]  flash_dq_in,
   output logic                          flash_ce_n,
   output logic                          flash_oe_n,
   output logic                          flash_we_n
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_RECOVER,
      ST_NEXT,
      ST_DONE
   } fcsm_state_type;

   localparam logic [7:0] SETUP_CYC   = 8'(`FCSM_SETUP_CYC);
   localparam logic [7:0] WE_CYC      = 8'(`FCSM_WE_CYC);
   localparam logic [7:0] ACCESS_CYC  = 8'(`FCSM_ACCESS_CYC);
   localparam logic [7:0] RECOVER_CYC = 8'(`FCSM_RECOVER_CYC);

   fcsm_state_type            state;
   fcsm_op_type               xop;
   logic                      byte_mode;
   logic [`FCSM_ADDR_W-1:0]   op_addr;
   logic [`FCSM_DATA_W-1:0]   op_data;
   logic [`FCSM_ADDR_W-1:0]   erase_addr;
   logic [2:0]                step;
   logic [7:0]                timer;
   logic                      polling;
   logic                      first_seen;
   logic                      prev_toggle;
   logic                      prev_limit;
   logic                      aborted;
   logic                      suspended;
   logic                      sector_active;
   logic                      erase_held;
   logic [`FCSM_DATA_W-1:0]   sync_a;
   logic [`FCSM_DATA_W-1:0]   sync_b;
   logic [`FCSM_DATA_W-1:0]   rd_data;
   fcsm_bus_type              entry;

   // Two-stage synchroniser on the data pins; only sync_b is read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (clk_en) begin
         sync_a <= flash_dq_in;
         sync_b <= sync_a;
      end
   end

   // [RULE12] mode-dependent unlock addresses
   wire [`FCSM_ADDR_W-1:0] ul1 = byte_mode ? `FCSM_UNLOCK1_BYTE
                                           : `FCSM_UNLOCK1_WORD;
   wire [`FCSM_ADDR_W-1:0] ul2 = byte_mode ? `FCSM_UNLOCK2_BYTE
                                           : `FCSM_UNLOCK2_WORD;
   // [RULE15] protect state sits at a fixed offset in the sector
   wire [`FCSM_ADDR_W-1:0] prot_addr = (op_addr & `FCSM_SECTOR_MASK) |
      (byte_mode ? `FCSM_PROT_OFS_BYTE : `FCSM_PROT_OFS_WORD);
   wire is_single = (xop == OP_READ) || (xop == OP_RESET) ||
                    (xop == OP_SUSPEND) || (xop == OP_RESUME);
   wire is_short  = (xop == OP_IDENT) || (xop == OP_PROT_VERIFY) ||
                    (xop == OP_PROGRAM);
   wire [2:0] last_step = is_single ? 3'h0 : (is_short ? 3'h3 : 3'h5);
   wire [`FCSM_DATA_W-1:0] setup_code =
      (xop == OP_PROGRAM) ? `FCSM_CODE_PROGRAM :
      ((xop == OP_IDENT) || (xop == OP_PROT_VERIFY)) ? `FCSM_CODE_IDENT :
      `FCSM_CODE_ERASE_SET;
   // Resume only polls when an erase was really held
   wire needs_poll = (xop == OP_PROGRAM) || (xop == OP_CHIP_ERASE) ||
                     (xop == OP_SECTOR_ERASE) ||
                     ((xop == OP_RESUME) && erase_held);
   wire poll_toggle = rd_data[`FCSM_TOGGLE_BIT];
   wire poll_limit  = rd_data[`FCSM_LIMIT_BIT];
   wire take_suspend = cmd_ready && cmd_valid && (cmd.op == OP_SUSPEND);

   // Bus cycle for the current step of the current operation
   always_comb begin
      entry = '{addr: '0, data: '0, is_read: 1'b0};
      if (polling) begin
         entry = '{addr: (xop == OP_PROGRAM) ? op_addr : erase_addr,
                   data: '0, is_read: 1'b1};
      end else if (is_single) begin
         case (xop)
            OP_READ:    entry = '{addr: op_addr, data: '0, is_read: 1'b1};
            // [RULE18] single abort write
            OP_RESET:   entry.data = `FCSM_CODE_RESET;
            // [RULE19] suspend and resume codes
            OP_SUSPEND: entry.data = `FCSM_CODE_SUSPEND;
            default:    entry.data = `FCSM_CODE_RESUME;
         endcase
      end else begin
         // [RULE13] unlock cycles drive the upper bits low
         case (step)
            3'h0:    entry = '{addr: ul1, data: `FCSM_CODE_UNLOCK1, is_read: 1'b0};
            3'h1:    entry = '{addr: ul2, data: `FCSM_CODE_UNLOCK2, is_read: 1'b0};
            // [RULE1] set-up code after two unlocks
            3'h2:    entry = '{addr: ul1, data: setup_code, is_read: 1'b0};
            3'h3: begin
               case (xop)
                  // [RULE14] identifier read after 90
                  OP_IDENT:       entry = '{addr: op_addr, data: '0, is_read: 1'b1};
                  OP_PROT_VERIFY: entry = '{addr: prot_addr, data: '0, is_read: 1'b1};
                  // [RULE16] target address and value
                  OP_PROGRAM:     entry = '{addr: op_addr, data: op_data, is_read: 1'b0};
                  default:        entry = '{addr: ul1, data: `FCSM_CODE_UNLOCK1, is_read: 1'b0};
               endcase
            end
            3'h4:    entry = '{addr: ul2, data: `FCSM_CODE_UNLOCK2, is_read: 1'b0};
            default: begin
               // [RULE17] chip confirm; [RULE11] sector confirm at its address
               if (xop == OP_CHIP_ERASE) begin
                  entry = '{addr: ul1, data: `FCSM_CODE_CHIP, is_read: 1'b0};
               end else begin
                  entry = '{addr: op_addr, data: `FCSM_CODE_SECTOR, is_read: 1'b0};
               end
            end
         endcase
      end
   end

   // Main sequencer; strobe timing keeps the bus stable around both edges
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state         <= ST_IDLE;
         xop           <= OP_READ;
         byte_mode     <= 1'b0;
         op_addr       <= '0;
         op_data       <= '0;
         erase_addr    <= '0;
         step          <= 3'h0;
         timer         <= 8'h00;
         polling       <= 1'b0;
         first_seen    <= 1'b0;
         prev_toggle   <= 1'b0;
         prev_limit    <= 1'b0;
         aborted       <= 1'b0;
         suspended     <= 1'b0;
         sector_active <= 1'b0;
         erase_held    <= 1'b0;
         rd_data       <= '0;
         cmd_ready     <= 1'b1;
         rsp_valid     <= 1'b0;
         rsp           <= '0;
         flash_addr    <= '0;
         flash_dq_out  <= '0;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
      end else if (clk_en) begin
         case (state)
            ST_IDLE: begin
               rsp_valid <= 1'b0;
               if (cmd_valid) begin
                  cmd_ready  <= 1'b0;
                  xop        <= cmd.op;
                  byte_mode  <= cmd.byte_mode;
                  op_addr    <= cmd.addr;
                  op_data    <= cmd.data;
                  step       <= 3'h0;
                  polling    <= 1'b0;
                  first_seen <= 1'b0;
                  aborted    <= 1'b0;
                  suspended  <= 1'b0;
                  timer      <= SETUP_CYC;
                  state      <= ST_SETUP;
                  if ((cmd.op == OP_CHIP_ERASE) || (cmd.op == OP_SECTOR_ERASE)) begin
                     erase_addr <= cmd.addr;
                  end
               end
            end
            // [RULE6] address valid before either strobe falls
            ST_SETUP: begin
               flash_addr    <= entry.addr;
               flash_dq_out  <= entry.data;
               flash_dq_oe_n <= entry.is_read;
               flash_ce_n    <= 1'b0;
               if (timer != 8'h00) begin
                  timer <= timer - 8'h01;
               end else begin
                  flash_we_n <= entry.is_read;
                  flash_oe_n <= !entry.is_read;
                  timer      <= entry.is_read ? ACCESS_CYC : WE_CYC;
                  state      <= ST_STROBE;
               end
            end
            // [RULE6] data held across the rising strobe
            ST_STROBE: begin
               if (timer != 8'h00) begin
                  timer <= timer - 8'h01;
               end else begin
                  if (entry.is_read) begin
                     rd_data <= sync_b;
                  end
                  flash_we_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  timer      <= RECOVER_CYC;
                  state      <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               if (timer != 8'h00) begin
                  timer <= timer - 8'h01;
               end else begin
                  flash_ce_n    <= 1'b1;
                  flash_dq_oe_n <= 1'b1;
                  // [RULE8] only suspend is offered during a sector erase
                  cmd_ready     <= polling && sector_active;
                  state         <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               cmd_ready <= 1'b0;
               timer     <= SETUP_CYC;
               if (aborted) begin
                  sector_active <= 1'b0;
                  erase_held    <= 1'b0;
                  state         <= ST_DONE;
               end else if (take_suspend) begin
                  // [RULE9] erase held; device now reads the array
                  xop           <= OP_SUSPEND;
                  polling       <= 1'b0;
                  suspended     <= 1'b1;
                  erase_held    <= 1'b1;
                  sector_active <= 1'b0;
                  state         <= ST_SETUP;
               end else if (xop == OP_SUSPEND) begin
                  state <= ST_DONE;
               end else if (polling) begin
                  // [RULE2] [RULE3] wait for the toggle bit to settle
                  prev_toggle <= poll_toggle;
                  prev_limit  <= poll_limit;
                  first_seen  <= 1'b1;
                  if (first_seen && (poll_toggle == prev_toggle)) begin
                     // [RULE10] finished; full command set open again
                     sector_active <= 1'b0;
                     erase_held    <= 1'b0;
                     state         <= ST_DONE;
                  end else if (first_seen && poll_limit && prev_limit) begin
                     // [RULE18] limit on two reads; the first may be array data
                     xop     <= OP_RESET;
                     polling <= 1'b0;
                     aborted <= 1'b1;
                     state   <= ST_SETUP;
                  end else begin
                     state <= ST_SETUP;
                  end
               end else if (step != last_step) begin
                  step  <= step + 3'h1;
                  state <= ST_SETUP;
               end else if (needs_poll) begin
                  // [RULE7] while the device works only a suspend is taken, and only in a sector erase
                  polling       <= 1'b1;
                  first_seen    <= 1'b0;
                  sector_active <= (xop == OP_SECTOR_ERASE) ||
                                   (xop == OP_RESUME);
                  erase_held    <= 1'b0;
                  state         <= ST_SETUP;
               end else begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               rsp_valid      <= 1'b1;
               rsp.data       <= rd_data;
               rsp.fail       <= aborted;
               rsp.suspended  <= suspended;
               cmd_ready      <= 1'b1;
               state          <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule : fcsm_host

`default_nettype wire

// File: tb/fcsm_host_asserts.sv
// Purpose: Pin protocol checks on the flash command host.
// Assumes: One core_clk domain, resetn active low.
// Notes:   Bound onto fcsm_host from tb_top.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_params.svh"

module fcsm_host_asserts
   import fcsm_pkg::*;
(
   input wire logic                    core_clk,
   input wire logic                    resetn,
   input wire logic                    clk_en,
   input wire logic                    cmd_valid,
   input wire logic                    cmd_ready,
   input wire logic                    rsp_valid,
   input wire logic [`FCSM_ADDR_W-1:0] flash_addr,
   input wire logic [`FCSM_DATA_W-1:0] flash_dq_out,
   input wire logic                    flash_dq_oe_n,
   input wire logic                    flash_ce_n,
   input wire logic                    flash_oe_n,
   input wire logic                    flash_we_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Strobe and data qualification on the flash bus, plus command handshake, answer pulse and reset checks
   we_in_ce_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe outside chip select");
   write_drive_a: assert property (!flash_we_n |-> !flash_dq_oe_n)
      else $error("data not driven during write");
   read_release_a: assert property (!flash_oe_n |-> flash_dq_oe_n)
      else $error("host drives data during read");
   latch_stable_a: assert property (!flash_we_n && $past(!flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved under strobe");
   we_width_a: assert property ($fell(flash_we_n) |=> !flash_we_n [*8])
      else $error("write strobe too short");
   data_hold_a: assert property ($rose(flash_we_n) |->
      !flash_ce_n && !flash_dq_oe_n && $stable(flash_dq_out))
      else $error("data not held past strobe rise");
   take_drop_a: assert property (clk_en && cmd_valid && cmd_ready |=> !cmd_ready)
      else $error("ready stays high after a take");
   rsp_pulse_a: assert property (rsp_valid |-> flash_we_n && flash_oe_n ##1 !rsp_valid)
      else $error("answer not a single idle pulse");
   rst_idle_a: assert property ($rose(resetn) |-> cmd_ready && flash_ce_n &&
      flash_we_n && flash_oe_n && flash_dq_oe_n)
      else $error("bus not idle after reset");
endmodule : fcsm_host_asserts
`default_nettype wire

// File: tb/fcsm_flash_model.sv
// Purpose: Behavioural parallel NOR flash facing the host.
// Assumes: Host writes are strobe-controlled cycles.
// Notes:   No clock inside; busy time counts polling reads.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_params.svh"

module fcsm_flash_model #(
   parameter logic [15:0] MFR_ID   = 16'h0011, // Arbitrary value
   parameter logic [15:0] DEV_ID   = 16'h0022, // Arbitrary value
   parameter logic [15:0] PROT_VAL = 16'h0001,
   parameter int          PROG_RD  = 3,
   parameter int          ERASE_RD = 5
) (
   input  wire logic        byte_mode,
   input  wire logic        fail_inj,
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_wr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   output logic      [15:0] dq_rd
);
   logic [15:0] mem [logic [19:0]];
   logic [19:0] la, u1, u2, msk, sm;
   logic [15:0] pd = 16'hffff;
   logic [15:0] rd = 16'h0000;
   int step = 0;
   int busy = 0;
   int held = 0;
   logic ers = 1'b0, susp = 1'b0, ident = 1'b0, tgl = 1'b0;
   // unlock match on low bits only
   assign u1  = byte_mode ? 20'h00aaa : 20'h00555;
   assign u2  = byte_mode ? 20'h00555 : 20'h002aa;
   assign msk = byte_mode ? 20'h00fff : 20'h007ff;

   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      logic h1, h2;
      h1 = (a & msk) == u1;
      h2 = (a & msk) == u2;
      // only abort or suspend while busy
      if (busy > 0) begin
         if (fail_inj && d == 16'h00f0) busy = 0;
         else if (ers && d == 16'h00b0) begin
            held = busy;
            busy = 0;
            susp = 1'b1;
         end
      end else case (step)
         // resume only with a held erase; bad step resets
         0: if (h1 && d == 16'h00aa) step = 1;
            else if (d == 16'h00f0) ident = 1'b0;
            else if (d == 16'h0030 && susp) begin
               busy = held;
               susp = 1'b0;
            end
         1: step = (h2 && d == 16'h0055) ? 2 : 0;
         2: begin
            step = (h1 && d == 16'h00a0) ? 6 : (h1 && d == 16'h0080) ? 3 : 0;
            if (h1 && d == 16'h0090) ident = 1'b1;
         end
         3: step = (h1 && d == 16'h00aa) ? 4 : 0;
         4: step = (h2 && d == 16'h0055) ? 5 : 0;
         5: begin
            step = 0;
            if ((h1 && d == 16'h0010) || d == 16'h0030) begin
               sm = (d == 16'h0010) ? 20'h00000 : `FCSM_SECTOR_MASK;
               foreach (mem[k]) if ((k & sm) == (a & sm)) mem[k] = 16'hffff;
               ers = d == 16'h0030;
               pd = 16'hffff;
               busy = ERASE_RD;
            end
         end
         // program cycle carries address and value
         default: begin
            mem[a] = d;
            pd = d;
            ers = 1'b0;
            busy = PROG_RD;
            step = 0;
         end
      endcase
   endtask : wr

   // address on strobe fall, data on strobe rise
   always @(negedge we_n) if (!ce_n) la = addr;
   always @(posedge we_n) if (!ce_n) wr(la, dq_wr);

   always @(negedge oe_n) if (!ce_n) begin
      if (busy > 0) begin
         tgl = ~tgl;
         rd = {8'h00, ~pd[7], tgl, fail_inj, 5'h00};
         if (!fail_inj) busy = busy - 1;
      end else if (ident)
         rd = (byte_mode ? addr[2] : addr[1]) ? PROT_VAL :
              addr[0] ? DEV_ID : MFR_ID;
      else rd = mem.exists(addr) ? mem[addr] : 16'hffff;
   end
   // Released bus shows the inverse so stale data never looks valid
   assign dq_rd = (!ce_n && !oe_n) ? rd : ~rd;
endmodule : fcsm_flash_model
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the flash command host.
// Assumes: Inputs driven on falling core_clk edges.
// Notes:   Flash model counts busy time in polling reads.
`timescale 1ns/1ps
`default_nettype none
`include "fcsm_params.svh"

module tb_top;
   import fcsm_pkg::*;
   localparam logic [15:0] MFR = 16'h0011; // Arbitrary value
   localparam logic [15:0] DEV = 16'h0022; // Arbitrary value
   logic         core_clk = 1'b0;
   logic         resetn = 1'b0;
   logic         cmd_valid = 1'b0;
   logic         bm = 1'b0;
   logic         fail_inj = 1'b0;
   logic         ce = 1'b1;
   fcsm_cmd_type cmd = '0;
   fcsm_rsp_type rsp;
   logic         cmd_ready, rsp_valid, dq_oe_n, ce_n, oe_n, we_n;
   logic [19:0]  fa;
   logic [15:0]  dq_out, dq_rd, dq_in;
   int           fails = 0;
   int           n_compared = 0;

   always #2 core_clk = ~core_clk;
   // Wire level: host value while it drives, else the flash
   assign dq_in = !dq_oe_n ? dq_out : dq_rd;

   fcsm_host dut (.core_clk(core_clk), .resetn(resetn), .clk_en(ce),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp(rsp), .flash_addr(fa),
      .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
   fcsm_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) flash (.byte_mode(bm),
      .fail_inj(fail_inj), .addr(fa), .dq_wr(dq_out), .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .dq_rd(dq_rd));

   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Bounded wait for a flag, checked at falling edges
   task automatic await(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'b1; i++) @(negedge core_clk);
      if (s !== 1'b1) begin
         check({15'h0000, s}, 16'h0001);
         summarize();
      end
   endtask : await

   task automatic req(input fcsm_op_type op, input logic [19:0] a,
                      input logic [15:0] d, input bit wt);
      @(negedge core_clk);
      await(cmd_ready, 4000);
      cmd = '{op, bm, a, d};
      cmd_valid = 1'b1;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      @(negedge core_clk);
      if (wt) await(rsp_valid, 20000);
   endtask : req

   task automatic t_program;
      req(OP_PROGRAM, 20'h12345, 16'h5a3c, 0);
      // Frozen clock enable must hold the first unlock cycle on the bus
      ce = 1'b0;
      repeat (40) @(negedge core_clk);
      check(fa[15:0], 16'h0555);
      ce = 1'b1;
      await(rsp_valid, 20000);
      check(rsp.data, 16'h5a3c);
      check({15'h0000, rsp.fail}, 16'h0000);
      req(OP_PROGRAM, 20'h34567, 16'h0f0f, 1);
      req(OP_READ, 20'h34567, 16'h0000, 1);
      check(rsp.data, 16'h0f0f);
      $display("test program done");
   endtask : t_program

   task automatic t_ident;
      req(OP_IDENT, 20'h00000, 16'h0000, 1);
      check(rsp.data, MFR);
      req(OP_IDENT, 20'h00001, 16'h0000, 1);
      check(rsp.data, DEV);
      req(OP_PROT_VERIFY, 20'h12345, 16'h0000, 1);
      check(rsp.data, 16'h0001);
      bm = 1'b1;
      req(OP_PROT_VERIFY, 20'h12345, 16'h0000, 1);
      check(rsp.data, 16'h0001);
      req(OP_RESET, 20'h00000, 16'h0000, 1);
      req(OP_READ, 20'h12345, 16'h0000, 1);
      check(rsp.data, 16'h5a3c);
      req(OP_PROGRAM, 20'h00101, 16'h00c3, 1);
      check(rsp.data, 16'h00c3);
      bm = 1'b0;
      $display("test ident and byte mode done");
   endtask : t_ident

   task automatic t_suspend;
      req(OP_SECTOR_ERASE, 20'h12300, 16'h0000, 0);
      req(OP_SUSPEND, 20'h00000, 16'h0000, 1);
      check({15'h0000, rsp.suspended}, 16'h0001);
      req(OP_READ, 20'h34567, 16'h0000, 1);
      check(rsp.data, 16'h0f0f);
      req(OP_RESUME, 20'h00000, 16'h0000, 1);
      check(rsp.data, 16'hffff);
      req(OP_READ, 20'h12345, 16'h0000, 1);
      check(rsp.data, 16'hffff);
      $display("test suspend done");
   endtask : t_suspend

   task automatic t_fail_chip;
      fail_inj = 1'b1;
      req(OP_PROGRAM, 20'h00200, 16'h1111, 1);
      fail_inj = 1'b0;
      check({15'h0000, rsp.fail}, 16'h0001);
      req(OP_READ, 20'h34567, 16'h0000, 1);
      check(rsp.data, 16'h0f0f);
      req(OP_CHIP_ERASE, 20'h00000, 16'h0000, 1);
      check(rsp.data, 16'hffff);
      req(OP_READ, 20'h34567, 16'h0000, 1);
      check(rsp.data, 16'hffff);
      $display("test fail and chip erase done");
   endtask : t_fail_chip

   initial begin
      repeat (8) @(negedge core_clk);
      resetn = 1'b1;
      t_program();
      t_ident();
      t_suspend();
      t_fail_chip();
      summarize();
   end
endmodule : tb_top

bind fcsm_host fcsm_host_asserts chk (.core_clk(core_clk), .resetn(resetn),
   .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire
